/* File: hdl/memory_security_firewall.sv */
// memory guard firewall: zone lock state, unlock sequence, access gate
`timescale 1ns/10ps
`default_nettype none
module memory_security_firewall
  import memory_guard_pkg::*;
#(
  parameter int NUM_ZONES = 2, // guards fitted
  parameter int NUM_CS = 8, // chip-select lines
  parameter logic [NUM_CS-1:0] CS_MASK0 = '0, // banks of guard one
  parameter logic [NUM_CS-1:0] CS_MASK1 = '0, // banks of guard two
  parameter logic [31:0] PWD_ADDR0 = 32'h0000_0000, // password block one
  parameter logic [31:0] PWD_ADDR1 = 32'h0000_0000 // password block two
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic bus_valid_i, // access request this cycle
  input wire logic [31:0] bus_addr_i, // byte address
  input wire logic bus_write_i, // 1 write, 0 read
  input wire logic [31:0] bus_wdata_i, // write data
  input wire logic bus_fetch_i, // instruction fetch
  input wire logic bus_priv_i, // privileged mode
  input wire logic bus_debug_i, // access from debug path
  input wire logic [NUM_CS-1:0] cs_hit_i, // target chip-select
  input wire logic dma_reg_hit_i, // target is DMA registers
  input wire logic dma_buf_hit_i, // target is DMA command RAM
  input wire logic [MAX_ZONES-1:0] wrap_hit_i, // flash wrapper regs
  input wire logic [PWD_BITS-1:0] pwd_zone0_i, // stored password one
  input wire logic [PWD_BITS-1:0] pwd_zone1_i, // stored password two
  output logic bus_grant_o, // access may proceed
  output logic bus_deny_o, // access blocked
  output logic rdata_valid_o, // firewall read data valid
  output logic [31:0] rdata_o, // register or password word
  output logic [MAX_ZONES-1:0] locked_o // lock state per guard
);

  // refuse impossible configurations
  if (NUM_ZONES < 1 || NUM_ZONES > MAX_ZONES) begin : g_bad_zones
    $error("NUM_ZONES must be 1 or 2");
  end
  if (NUM_CS < 1) begin : g_bad_cs
    $error("NUM_CS must be positive");
  end

  // per-guard constant tables
  localparam logic [31:0] BASE [MAX_ZONES] = '{GUARD_BASE0, GUARD_BASE1};
  localparam logic [31:0] PWDA [MAX_ZONES] = '{PWD_ADDR0, PWD_ADDR1};
  // guard two never claims banks of guard one
  localparam logic [NUM_CS-1:0] CSM [MAX_ZONES] =
    '{CS_MASK0, CS_MASK1 & ~CS_MASK0};

  // stored passwords as an array
  logic [PWD_BITS-1:0] pwd [MAX_ZONES];
  assign pwd[0] = pwd_zone0_i;
  assign pwd[1] = pwd_zone1_i;

  // address lies in a guard register page
  function automatic logic page_hit(input logic [31:0] a, input logic [31:0] b);
    page_hit = (a & PAGE_MASK) == b;
  endfunction : page_hit

  // address lies in a password block
  function automatic logic pwd_hit(input logic [31:0] a, input logic [31:0] b);
    pwd_hit = (a & PWD_BLOCK_MASK) == (b & PWD_BLOCK_MASK);
  endfunction : pwd_hit

  // word index inside a four-word group
  logic [1:0] widx;
  assign widx = bus_addr_i[WORD_LSB+1:WORD_LSB];

  // decoded targets per guard
  logic [MAX_ZONES-1:0] zone_tgt; // protected target of this access
  logic [MAX_ZONES-1:0] key_sel; // key word access
  logic [MAX_ZONES-1:0] scr_sel; // status/control access
  logic [MAX_ZONES-1:0] pwd_sel; // password block access
  logic [MAX_ZONES-1:0] lock_q; // lock state per guard
  logic public_vec; // vector window access

  // vectors stay public whatever the chip-select says
  assign public_vec = bus_addr_i <= VEC_TOP;

  // decode each guard's registers and protected targets
  always_comb begin
    zone_tgt = '0;
    key_sel = '0;
    scr_sel = '0;
    pwd_sel = '0;
    for (int z = 0; z < NUM_ZONES; z++) begin
      // banks by chip-select plus the zone's wrapper registers
      zone_tgt[z] = (|(cs_hit_i & CSM[z])) || wrap_hit_i[z];
      if (z == 0) begin
        // only guard one owns the DMA resources
        zone_tgt[z] = zone_tgt[z] || dma_reg_hit_i || dma_buf_hit_i;
      end
      // vector window is never protected
      zone_tgt[z] = zone_tgt[z] && !public_vec;
      // key page spans four words from the guard base
      key_sel[z] = page_hit(bus_addr_i, BASE[z]) &&
                   ((bus_addr_i[7:0] & KEY_SPAN_MASK) == KEY_OFFSET);
      scr_sel[z] = page_hit(bus_addr_i, BASE[z]) &&
                   (bus_addr_i[7:0] == SCR_OFFSET);
      pwd_sel[z] = pwd_hit(bus_addr_i, PWDA[z]);
    end
  end

  // zone that currently holds the program counter
  logic [MAX_ZONES-1:0] pc_zone_q, pc_zone_d;

  // gate: fetches pass except user-mode fetches of key words, data needs unlock or a non-debug access inside code
  logic [MAX_ZONES-1:0] block_z;
  logic key_unpriv;
  always_comb begin
    block_z = '0;
    for (int z = 0; z < NUM_ZONES; z++) begin
      // password reads feed the unlock sequence, data comes from us
      if (zone_tgt[z] && lock_q[z] && !bus_fetch_i && !pwd_sel[z]) begin
        // debug is always blocked, outside code is blocked
        block_z[z] = bus_debug_i || !pc_zone_q[z];
      end
    end
    // key words refuse user-mode access
    key_unpriv = (|key_sel[NUM_ZONES-1:0]) && !bus_priv_i;
  end

  // other targets are left alone
  // deny and grant are combinational, answered in the request cycle
  assign bus_deny_o = bus_valid_i && ((|block_z) || key_unpriv);
  assign bus_grant_o = bus_valid_i && !bus_deny_o;

  // remember where granted fetches come from
  // vector window fetches decode to no zone, so that code counts as outside
  always_comb begin
    pc_zone_d = pc_zone_q;
    if (bus_grant_o && bus_fetch_i && !bus_debug_i) begin
      pc_zone_d = zone_tgt;
    end
  end

  // program counter zone register
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      pc_zone_q <= '0;
    end else begin
      pc_zone_q <= pc_zone_d;
    end
  end

  // granted data access strobes
  // fetches never count as data reads, so they never mark a password read
  logic rd_stb, wr_stb;
  assign rd_stb = bus_grant_o && !bus_write_i && !bus_fetch_i;
  assign wr_stb = bus_grant_o && bus_write_i;

  // per-guard unlock sequence state
  logic [MAX_ZONES-1:0][PWD_WORDS-1:0][31:0] key_q; // key entry words
  logic [MAX_ZONES-1:0][PWD_WORDS-1:0] rd_seen_q; // password words read
  logic [MAX_ZONES-1:0][PWD_WORDS-1:0] wr_seen_q; // key words written

  for (genvar g = 0; g < MAX_ZONES; g++) begin : g_guard
    if (g < NUM_ZONES) begin : g_on
      logic [PWD_WORDS-1:0][31:0] key_d;
      logic [PWD_WORDS-1:0] rd_d, wr_d;
      logic lock_d;
      logic pw_ones, pw_zero, key_match;

      // password class and key compare
      assign pw_ones = &pwd[g];
      assign pw_zero = ~|pwd[g];
      assign key_match = key_q[g] == pwd[g];

      // next state of the unlock sequence
      always_comb begin
        key_d = key_q[g];
        rd_d = rd_seen_q[g];
        wr_d = wr_seen_q[g];
        lock_d = lock_q[g];
        // compare first, so a mark taken in the compare cycle
        // is set after the clear and is not lost
        if (lock_q[g] && (&rd_seen_q[g])) begin
          if (pw_ones) begin
            // erased password: reads alone unlock
            lock_d = 1'b0;
          end else if (&wr_seen_q[g]) begin
            // full sequence done: compare once
            lock_d = !(key_match && !pw_zero);
            rd_d = '0;
            wr_d = '0;
          end
        end
        // a password word read counts toward the sequence
        if (rd_stb && pwd_sel[g] && lock_q[g]) begin
          rd_d[widx] = 1'b1;
        end
        // key words load from privileged writes
        if (wr_stb && key_sel[g]) begin
          key_d[widx] = bus_wdata_i;
          wr_d[widx] = 1'b1;
        end
        // force-lock wins over everything else
        if (wr_stb && scr_sel[g] && bus_wdata_i[FORCE_LOCK_BIT]) begin
          key_d = '0;
          rd_d = '0;
          wr_d = '0;
          lock_d = 1'b1;
        end
      end

      // guard registers, locked out of reset
      always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
          key_q[g] <= '0;
          rd_seen_q[g] <= '0;
          wr_seen_q[g] <= '0;
          lock_q[g] <= 1'b1;
        end else begin
          key_q[g] <= key_d;
          rd_seen_q[g] <= rd_d;
          wr_seen_q[g] <= wr_d;
          lock_q[g] <= lock_d;
        end
      end
    end else begin : g_off
      // absent guard: nothing protected, nothing stored
      assign key_q[g] = '0;
      assign rd_seen_q[g] = '0;
      assign wr_seen_q[g] = '0;
      assign lock_q[g] = 1'b0;
    end
  end

  // lock state straight from the guard registers
  // an absent guard reports unlocked since it protects nothing
  assign locked_o = lock_q;

  // read data for registers and password words
  logic [31:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  always_comb begin
    rdata_d = WORD_ZERO;
    rvalid_d = 1'b0;
    for (int z = 0; z < NUM_ZONES; z++) begin
      if (rd_stb && scr_sel[z]) begin
        // force-lock and reserved bits read zero
        rdata_d = WORD_ZERO;
        rdata_d[LOCK_STATE_BIT] = lock_q[z];
        rvalid_d = 1'b1;
      end else if (rd_stb && key_sel[z]) begin
        // key words are never echoed back
        rvalid_d = 1'b1;
      end else if (rd_stb && pwd_sel[z]) begin
        // real words only once unlocked
        if (!lock_q[z]) begin
          rdata_d = pwd[z][widx*32 +: 32];
        end
        rvalid_d = 1'b1;
      end
    end
  end

  // registered read answer
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      rdata_q <= WORD_ZERO;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign rdata_o = rdata_q;
  assign rdata_valid_o = rvalid_q;

endmodule : memory_security_firewall
`default_nettype wire

/* File: hdl/memory_guard_pkg.sv */
// constants shared by the memory guard firewall
package memory_guard_pkg;
  // number of zone guards the fabric can hold
  localparam int MAX_ZONES = 2;
  // words in a stored password / key entry set
  localparam int PWD_WORDS = 4;
  localparam int PWD_BITS = 128;
  // register page base of each guard
  localparam logic [31:0] GUARD_BASE0 = 32'hFFFF_F700;
  localparam logic [31:0] GUARD_BASE1 = 32'hFFFF_F600;
  // offsets inside a guard page
  localparam logic [7:0] KEY_OFFSET = 8'h00;
  localparam logic [7:0] SCR_OFFSET = 8'h24;
  // key words occupy offsets 0x00..0x0c
  localparam logic [7:0] KEY_SPAN_MASK = 8'hF0;
  // guard_status_control fields
  localparam int FORCE_LOCK_BIT = 31;
  localparam int LOCK_STATE_BIT = 0;
  // interrupt vector window that stays public
  localparam logic [31:0] VEC_TOP = 32'h0000_001F;
  // page and password block compare masks
  localparam logic [31:0] PAGE_MASK = 32'hFFFF_FF00;
  localparam logic [31:0] PWD_BLOCK_MASK = 32'hFFFF_FFF0;
  // word index field of an address
  localparam int WORD_LSB = 2;
  // all zero word for cleared state
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
endpackage : memory_guard_pkg

/* File: verification/cpu_bus_model.sv */
// processor and debug side bus master model
`timescale 1ns/10ps
`default_nettype none
module cpu_bus_model (
  input wire logic clk_sys_i,
  input wire logic deny_i,
  input wire logic rv_i,
  input wire logic [31:0] rd_i,
  output logic valid_o,
  output logic [31:0] addr_o,
  output logic write_o,
  output logic [31:0] wdata_o,
  output logic [2:0] mode_o, // fetch, privileged, debug
  output logic [11:0] ct_o // chip-selects, dma regs, dma ram, wrappers
);
  logic den, rv; // deny and answer flag of the last request
  logic [31:0] rd; // answer data of the last request
  initial {valid_o, addr_o, write_o, wdata_o, mode_o, ct_o} = '0;
  // request at a falling edge, held over the sampling rising edge
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
      input logic [2:0] m, input logic [11:0] c);
    @(negedge clk_sys_i);
    {valid_o, addr_o, write_o, wdata_o, mode_o, ct_o} = {1'b1, a, w, d, m, c};
    #10 den = deny_i;
    @(negedge clk_sys_i);
    {rv, rd} = {rv_i, rd_i};
    {valid_o, addr_o, wdata_o} = {1'b0, ~a, ~d}; // released lines drop old value
  endtask : xfer
endmodule : cpu_bus_model
`default_nettype wire

/* File: verification/memory_security_firewall_checker.sv */
// port assertions for the memory security firewall
`timescale 1ns/10ps
`default_nettype none
module fw_checker
  import memory_guard_pkg::*;
#(parameter int NUM_CS = 8, parameter logic [NUM_CS-1:0] CS_MASK0 = '0,
  parameter logic [31:0] PWD_ADDR0 = 32'h0000_0000) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic bus_valid_i,
  input wire logic [31:0] bus_addr_i,
  input wire logic bus_write_i,
  input wire logic [31:0] bus_wdata_i,
  input wire logic bus_fetch_i,
  input wire logic bus_priv_i,
  input wire logic bus_debug_i,
  input wire logic [NUM_CS-1:0] cs_hit_i,
  input wire logic bus_grant_o,
  input wire logic bus_deny_o,
  input wire logic rdata_valid_o,
  input wire logic [31:0] rdata_o,
  input wire logic [1:0] locked_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  wire logic tk = bus_valid_i && bus_grant_o; // request taken
  wire logic scr = bus_addr_i == 32'hFFFF_F724; // guard one status word
  a_grant_deny_excl: assert property ((bus_grant_o ^ bus_deny_o) == bus_valid_i)
    else $error("grant and deny clash");
  a_vector_public: assert property (bus_valid_i && bus_addr_i <= VEC_TOP |-> bus_grant_o)
    else $error("vector access denied");
  a_fetch_passes: assert property (bus_valid_i && bus_fetch_i && bus_priv_i |-> bus_grant_o)
    else $error("fetch denied");
  a_reset_locks: assert property ($fell(reset_i) |-> locked_o == 2'b11)
    else $error("not locked after reset");
  a_force_relocks: assert property (tk && bus_write_i && scr && bus_wdata_i[31] |=>
    locked_o[0]) else $error("force lock ignored");
  a_status_read: assert property (tk && !bus_write_i && !bus_fetch_i && scr |=>
    rdata_valid_o && !rdata_o[31] && rdata_o[0] == $past(locked_o[0])) else $error("bad status");
  a_key_priv_only: assert property (bus_valid_i && !bus_priv_i &&
    bus_addr_i[31:4] == GUARD_BASE0[31:4] |-> bus_deny_o) else $error("key open to user");
  a_debug_blocked: assert property (bus_valid_i && bus_debug_i && !bus_fetch_i &&
    locked_o[0] && |(cs_hit_i & CS_MASK0) && bus_addr_i > VEC_TOP &&
    bus_addr_i[31:4] != PWD_ADDR0[31:4] |-> bus_deny_o) else $error("debug not blocked");
endmodule : fw_checker
bind memory_security_firewall fw_checker #(.NUM_CS(NUM_CS), .CS_MASK0(CS_MASK0),
  .PWD_ADDR0(PWD_ADDR0)) chk_i (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
  .bus_valid_i(bus_valid_i), .bus_addr_i(bus_addr_i), .bus_write_i(bus_write_i),
  .bus_wdata_i(bus_wdata_i), .bus_fetch_i(bus_fetch_i), .bus_priv_i(bus_priv_i),
  .bus_debug_i(bus_debug_i), .cs_hit_i(cs_hit_i), .bus_grant_o(bus_grant_o),
  .bus_deny_o(bus_deny_o), .rdata_valid_o(rdata_valid_o), .rdata_o(rdata_o),
  .locked_o(locked_o));
`default_nettype wire

/* File: verification/memory_security_firewall_tb.sv */
// self-checking bench for the memory security firewall
`timescale 1ns/10ps
`default_nettype none
module memory_security_firewall_tb;
  import memory_guard_pkg::*;
  logic clk_sys_i, reset_i;
  logic [127:0] pw0, pw1; // stored passwords
  logic [1:0] el, pcz; // expected locks, zone of last fetch (2 none)
  integer n_mismatch, n_checks, seed;
  wire logic vld, wr, gnt, dny, rv;
  wire logic [31:0] adr, wd, rd;
  wire logic [2:0] md;
  wire logic [11:0] ct;
  wire logic [1:0] lk;
  logic [11:0] tt [7] = '{12'h010, 12'h020, 12'h800, 12'h008, 12'h004, 12'h002, 12'h001};
  cpu_bus_model bm (.clk_sys_i(clk_sys_i), .deny_i(dny), .rv_i(rv), .rd_i(rd), .valid_o(vld),
    .addr_o(adr), .write_o(wr), .wdata_o(wd), .mode_o(md), .ct_o(ct));
  memory_security_firewall #(.NUM_CS(8), .CS_MASK0(8'h01), .CS_MASK1(8'h02),
    .PWD_ADDR0(32'h0001_0000), .PWD_ADDR1(32'h0002_0000)) dut (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .bus_valid_i(vld), .bus_addr_i(adr),
    .bus_write_i(wr), .bus_wdata_i(wd), .bus_fetch_i(md[2]), .bus_priv_i(md[1]),
    .bus_debug_i(md[0]), .cs_hit_i(ct[11:4]), .dma_reg_hit_i(ct[3]), .dma_buf_hit_i(ct[2]),
    .wrap_hit_i(ct[1:0]), .pwd_zone0_i(pw0), .pwd_zone1_i(pw1), .bus_grant_o(gnt),
    .bus_deny_o(dny), .rdata_valid_o(rv), .rdata_o(rd), .locked_o(lk));
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input string nm, input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // expected block decision from modelled locks and fetch zone
  function automatic logic exp_deny(input logic [31:0] a, input logic [2:0] m, input logic [1:0] z);
    return !m[2] && a > VEC_TOP && z < 2 && el[z[0]] && (m[0] || pcz != z);
  endfunction : exp_deny
  // random gate traffic over all target kinds, privileged modes only
  task automatic sweep;
    logic [31:0] a;
    logic [2:0] m;
    logic [11:0] c;
    logic [1:0] z;
    for (int j = 0; j < 40; j++) begin
      a = $random(seed) & 32'h3000_003F;
      m = 3'($random(seed)) | 3'h2;
      c = tt[$unsigned($random(seed)) % 7];
      z = (c[4] | c[3] | c[2] | c[0]) ? 2'h0 : (c[5] | c[1]) ? 2'h1 : 2'h2;
      bm.xfer(a, a[5], a, m, c);
      chk("deny", 32'(bm.den), 32'(exp_deny(a, m, z)));
      if (m[2] && !m[0]) pcz = (a > VEC_TOP) ? z : 2'h2;
    end
  endtask : sweep
  // stored word reads, then privileged key writes, then the compare edge
  task automatic unlock(input logic z, input logic [127:0] k, input int nr, input int nk);
    for (int j = 0; j < nr; j++) bm.xfer((32'h0001_0000 << z) | 32'(4 * j), 1'b0, 32'h0, 3'h2,
      12'h0);
    for (int j = 0; j < nk; j++) bm.xfer((z ? GUARD_BASE1 : GUARD_BASE0) | 32'(4 * j), 1'b1,
      k[32 * j +: 32], 3'h2, 12'h0);
    @(negedge clk_sys_i);
  endtask : unlock
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  initial begin
    seed = 74742;
    n_mismatch = 0;
    n_checks = 0;
    pw0 = {$random(seed), $random(seed), $random(seed), $random(seed)} | 128'h1;
    pw1 = '1;
    for (int r = 0; r < 2; r++) begin
      reset_i = 1'b1;
      repeat (4) @(negedge clk_sys_i);
      reset_i = 1'b0;
      {el, pcz} = 4'hE;
      if (r == 1) begin
        unlock(1'b0, pw0, 4, 4);
        chk("lock", 32'(lk), 32'h3);
        $display("test zero password done");
      end else begin
        chk("lock", 32'(lk), 32'h3);
        bm.xfer(32'hFFFF_F724, 1'b0, 32'h0, 3'h2, 12'h0);
        chk("status", 32'({bm.rv, bm.rd[31], bm.rd[0]}), 32'h5);
        sweep();
        unlock(1'b0, pw0 ^ 128'h1, 4, 4);
        chk("lock", 32'(lk), 32'h3);
        bm.xfer(GUARD_BASE0, 1'b1, pw0[31:0], 3'h0, 12'h0);
        chk("deny", 32'(bm.den), 32'h1);
        unlock(1'b0, pw0, 4, 4);
        el[0] = 1'b0;
        chk("lock", 32'(lk), 32'h2);
        bm.xfer(32'h0001_0008, 1'b0, 32'h0, 3'h1, 12'h0);
        chk("stored", bm.rd, pw0[95:64]);
        bm.xfer(32'hFFFF_F724, 1'b1, 32'h7FFF_FFFF, 3'h2, 12'h0);
        chk("lock", 32'(lk), 32'h2);
        sweep();
        bm.xfer(32'hFFFF_F724, 1'b1, 32'h8000_0000, 3'h2, 12'h0);
        el[0] = 1'b1;
        chk("lock", 32'(lk), 32'h3);
        unlock(1'b0, pw0, 0, 4);
        chk("lock", 32'(lk), 32'h3);
        unlock(1'b1, pw1, 4, 0);
        el[1] = 1'b0;
        chk("lock", 32'(lk), 32'h1);
        sweep();
        $display("test unlock and gate done");
        pw0 = '0;
      end
    end
    tally_and_finish();
  end
endmodule : memory_security_firewall_tb
`default_nettype wire
